/* logic/sxp_pkg.sv */
// shared constants for the static switch processor and its tile end
// assumes both ends run on one clock; each end takes its own synchronous reset
package sxp_pkg;
  localparam int W          = 32;
  localparam int IMEM_DEPTH = 8096;
  localparam int PC_W       = 13;
  localparam int NREG       = 4;
  localparam int N_IN       = 9;
  localparam int N_OUT      = 10;
  localparam int N_NB       = 8;
  localparam int SEL_W      = 4;
  localparam int INST_W     = 64;
  localparam int FIFO_DEPTH = 2;

  // instruction fields
  localparam int F_OP_LSB    = 62;
  localparam int F_DST_LSB   = 60;
  localparam int F_SRC_LSB   = 56;
  localparam int F_TGT_LSB   = 40;
  localparam int F_ROUTE_LSB = 0;
  localparam int ROUTE_W     = N_OUT * SEL_W;

  typedef enum logic [1:0] {
    SXP_OP_NOP  = 2'h0,
    SXP_OP_MOVE = 2'h1,
    SXP_OP_BEQZ = 2'h2,
    SXP_OP_JUMP = 2'h3
  } sxp_op_t;

  // source / route selector codes: 1..9 name input queues,
  // c..f name registers (instruction source only)
  localparam logic [SEL_W-1:0] SEL_NONE     = 4'h0;
  localparam logic [SEL_W-1:0] SEL_PORT_LO  = 4'h1;
  localparam logic [SEL_W-1:0] SEL_PORT_HI  = 4'h9;
  localparam logic [1:0]       SEL_REG_TAG  = 2'h3;

  // input queue index 0 is the processor queue, 1..8 the neighbours:
  // north_in_net1, east_in_net1, south_in_net1, west_in_net1,
  // north_in_net2, east_in_net2, south_in_net2, west_in_net2
  localparam int IN_PROC = 0;
  // output index 0/1 feed the processor (queue a, switch_to_processor
  // _queue_b), 2..9 the neighbours in the same order as the inputs
  localparam int OUT_NB_BASE = 2;

  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] PC_LAST  = 13'h1f9f;
endpackage

/* logic/sxp_link_if.sv */
// link between the tile processor end and the switch end
// assumes both ends share clock; no clocking block
`timescale 1ns/10ps
interface sxp_link_if;
  logic                         to_sw_valid;
  logic [sxp_pkg::W-1:0]        to_sw_data;
  logic                         to_sw_ready;
  logic [1:0]                   from_sw_valid;
  logic [sxp_pkg::W-1:0]        from_sw_data_a;
  logic [sxp_pkg::W-1:0]        from_sw_data_b;
  logic [1:0]                   from_sw_rd;
  logic                         imem_we;
  logic [sxp_pkg::PC_W-1:0]     imem_addr;
  logic [sxp_pkg::INST_W-1:0]   imem_wdata;

  modport sw (
    input  to_sw_valid, to_sw_data, from_sw_rd,
    input  imem_we, imem_addr, imem_wdata,
    output to_sw_ready, from_sw_valid, from_sw_data_a, from_sw_data_b
  );
  modport tile (
    output to_sw_valid, to_sw_data, from_sw_rd,
    output imem_we, imem_addr, imem_wdata,
    input  to_sw_ready, from_sw_valid, from_sw_data_a, from_sw_data_b
  );
endinterface

/* logic/sxp_switch.sv */
// static switch processor: instruction store, four registers, queues
// assumes neighbours are switches on the same clock and the tile end
// loads the instruction store over the link
//
// Function
// - private uncached 8096-entry store, no data memory
// - tile processor loads and swaps the store
// - only move, branch, jump and nop
// - exactly four general registers
// - results to registers; sources registers or ports
// - processor queues plus two per neighbour
// - route part runs alongside the instruction
// - many transfers per cycle, fan-out allowed
// - stall whole instruction on full/empty port
// - link word arrives at end of cycle
// - neighbour word takes five cycles end to end
// - send-to-use latency is three cycles
// - processor writes queue in switch; reads remove
// - processor blocks on empty read or full write
`timescale 1ns/10ps
module sxp_fifo2 #(
  parameter int WIDTH = 32
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [sxp_pkg::FIFO_DEPTH];
  logic             wptr;
  logic             rptr;
  logic [1:0]       cnt;
  logic [1:0]       next_cnt;
  logic             full;
  logic             empty;
  wire              push = ce & in_valid & ~full;
  wire              pop  = ce & out_ready & ~empty;

  // ready and valid are kept as flops so the link pins come from a flop
  assign next_cnt  = cnt + {1'b0, push} - {1'b0, pop};
  assign full      = ~in_ready;
  assign empty     = ~out_valid;
  assign out_data  = mem[rptr];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wptr  <= 1'b0;
      rptr  <= 1'b0;
      cnt       <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) begin
        mem[wptr] <= in_data;
        wptr      <= ~wptr;
      end
      if (pop)
        rptr <= ~rptr;
      cnt       <= next_cnt;
      in_ready  <= next_cnt != 2'h2;
      out_valid <= next_cnt != 2'h0;
    end
  end
endmodule

module sxp_switch (
  input  wire logic                                clock,
  input  wire logic                                sys_rst,
  input  wire logic                                ce,
  sxp_link_if.sw                                   link,
  input  wire logic [sxp_pkg::N_NB-1:0]            nb_in_valid,
  input  wire logic [sxp_pkg::N_NB-1:0][sxp_pkg::W-1:0] nb_in_data,
  output logic [sxp_pkg::N_NB-1:0]                 nb_in_ready,
  output logic [sxp_pkg::N_NB-1:0]                 nb_out_valid,
  output logic [sxp_pkg::N_NB-1:0][sxp_pkg::W-1:0] nb_out_data,
  input  wire logic [sxp_pkg::N_NB-1:0]            nb_out_ready,
  output logic                                     stalled
);
  localparam int NI = sxp_pkg::N_IN;
  localparam int NO = sxp_pkg::N_OUT;
  localparam int SW = sxp_pkg::SEL_W;

  // instruction store only; the switch has no data memory
  logic [sxp_pkg::INST_W-1:0] imem [sxp_pkg::IMEM_DEPTH];
  logic [sxp_pkg::W-1:0]      regs [sxp_pkg::NREG];
  logic [sxp_pkg::PC_W-1:0]   pc;
  logic [sxp_pkg::PC_W-1:0]   next_pc;

  logic [NI-1:0]         q_push;
  logic [NI-1:0]         q_ready;
  logic [NI-1:0]         q_valid;
  logic [NI-1:0]         q_pop;
  logic [NI-1:0]         in_used;
  logic [sxp_pkg::W-1:0] q_wdata [NI];
  logic [sxp_pkg::W-1:0] q_rdata [NI];
  logic [NO-1:0]         out_act;
  logic [NO-1:0]         out_full;
  logic [sxp_pkg::W-1:0] out_word [NO];
  logic [NO-1:0]         hit_by [NI];
  logic [1:0]            sp_ready;

  wire [sxp_pkg::INST_W-1:0] inst = imem[pc];
  wire sxp_pkg::sxp_op_t op =
    sxp_pkg::sxp_op_t'(inst[sxp_pkg::F_OP_LSB +: 2]);
  wire [1:0] dst = inst[sxp_pkg::F_DST_LSB +: 2];
  wire [SW-1:0] src = inst[sxp_pkg::F_SRC_LSB +: SW];
  wire [sxp_pkg::PC_W-1:0] tgt = inst[sxp_pkg::F_TGT_LSB +: sxp_pkg::PC_W];
  wire [sxp_pkg::ROUTE_W-1:0] route =
    inst[sxp_pkg::F_ROUTE_LSB +: sxp_pkg::ROUTE_W];

  // operand may be a register or any input queue
  wire src_is_port = src >= sxp_pkg::SEL_PORT_LO &&
                     src <= sxp_pkg::SEL_PORT_HI;
  wire src_is_reg  = src[SW-1:SW-2] == sxp_pkg::SEL_REG_TAG;
  wire [SW-1:0] src_idx = SW'(src - sxp_pkg::SEL_PORT_LO);
  wire op_reads    = op != sxp_pkg::SXP_OP_NOP;
  wire [sxp_pkg::W-1:0] src_val =
    src_is_reg  ? regs[src[1:0]] :
    src_is_port ? q_rdata[src_idx] : '0;

  // every named port must be ready or nothing happens
  wire in_ok  = &(~in_used | q_valid);
  wire out_ok = &(~out_act | ~out_full);
  wire fire   = ce & in_ok & out_ok;
  wire [sxp_pkg::PC_W-1:0] pc_inc =
    (pc == sxp_pkg::PC_LAST) ? sxp_pkg::PC_RESET : pc + 13'h0001;

  // processor input queue plus two per neighbour
  assign q_push[sxp_pkg::IN_PROC]  = link.to_sw_valid;
  assign q_wdata[sxp_pkg::IN_PROC] = link.to_sw_data;
  assign link.to_sw_ready          = q_ready[sxp_pkg::IN_PROC];
  assign nb_in_ready               = q_ready[NI-1:1];

  genvar i;
  genvar o;
  generate
    for (i = 1; i < NI; i++) begin : g_nb_in
      assign q_push[i]  = nb_in_valid[i-1];
      assign q_wdata[i] = nb_in_data[i-1];
    end
    for (i = 0; i < NI; i++) begin : g_in
      sxp_fifo2 #(.WIDTH(sxp_pkg::W)) u_q (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .in_valid  (q_push[i]),
        .in_data   (q_wdata[i]),
        .in_ready  (q_ready[i]),
        .out_valid (q_valid[i]),
        .out_data  (q_rdata[i]),
        .out_ready (q_pop[i])
      );
      for (o = 0; o < NO; o++) begin : g_hit
        assign hit_by[i][o] = route[o*SW +: SW] == SW'(i + 1);
      end
      // a word copied to several outputs is removed once
      assign in_used[i] = (op_reads & src_is_port & src_idx == SW'(i)) |
                          (|hit_by[i]);
      assign q_pop[i]   = fire & in_used[i];
    end
    // route part: one selector per output, all act together
    for (o = 0; o < NO; o++) begin : g_out
      wire [SW-1:0] sel = route[o*SW +: SW];
      assign out_act[o]  = sel >= sxp_pkg::SEL_PORT_LO &&
                           sel <= sxp_pkg::SEL_PORT_HI;
      assign out_word[o] = out_act[o] ?
                           q_rdata[SW'(sel - sxp_pkg::SEL_PORT_LO)] : '0;
    end
    for (o = 0; o < 2; o++) begin : g_to_proc
      assign out_full[o] = ~sp_ready[o];
    end
    // neighbour output register: word is at the far end after the
    // edge that ends the routing cycle
    for (o = sxp_pkg::OUT_NB_BASE; o < NO; o++) begin : g_to_nb
      localparam int K = o - sxp_pkg::OUT_NB_BASE;
      // a draining register counts as free, so no bubble per word
      assign out_full[o] = nb_out_valid[K] & ~nb_out_ready[K];
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          nb_out_valid[K] <= 1'b0;
          nb_out_data[K]  <= '0;
        end else if (ce) begin
          if (fire & out_act[o]) begin
            nb_out_valid[K] <= 1'b1;
            nb_out_data[K]  <= out_word[o];
          end else if (nb_out_ready[K])
            nb_out_valid[K] <= 1'b0;
        end
      end
    end
  endgenerate

  // switch-to-processor queues a and b; tile pops them by reading
  sxp_fifo2 #(.WIDTH(sxp_pkg::W)) u_to_proc_a (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (fire & out_act[0]),
    .in_data   (out_word[0]),
    .in_ready  (sp_ready[0]),
    .out_valid (link.from_sw_valid[0]),
    .out_data  (link.from_sw_data_a),
    .out_ready (link.from_sw_rd[0])
  );
  sxp_fifo2 #(.WIDTH(sxp_pkg::W)) switch_to_processor_queue_b (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .in_valid  (fire & out_act[1]),
    .in_data   (out_word[1]),
    .in_ready  (sp_ready[1]),
    .out_valid (link.from_sw_valid[1]),
    .out_data  (link.from_sw_data_b),
    .out_ready (link.from_sw_rd[1])
  );

  // only nop, move, branch-if-zero and jump exist
  always_comb begin
    case (op)
      sxp_pkg::SXP_OP_BEQZ: next_pc = (src_val == '0) ? tgt : pc_inc;
      sxp_pkg::SXP_OP_JUMP:
        next_pc = (src == sxp_pkg::SEL_NONE) ? tgt
                                             : src_val[sxp_pkg::PC_W-1:0];
      default: next_pc = pc_inc;
    endcase
  end

  // store is written only by the tile end, never cached
  always_ff @(posedge clock) begin
    if (ce && link.imem_we)
      imem[link.imem_addr] <= link.imem_wdata;
  end

  // four registers, written only by a move that fires
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int r = 0; r < sxp_pkg::NREG; r++)
        regs[r] <= '0;
    end else if (fire && op == sxp_pkg::SXP_OP_MOVE) begin
      regs[dst] <= src_val;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc      <= sxp_pkg::PC_RESET;
      stalled <= 1'b0;
    end else if (ce) begin
      if (fire)
        pc <= next_pc;
      stalled <= ~(in_ok & out_ok);
    end
  end
endmodule

/* logic/sxp_tile.sv */
// tile processor end of the switch link: one write queue port, two
// read queues, instruction store loading
// assumes the pipeline above holds a request until it is accepted
`timescale 1ns/10ps
module sxp_tile (
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  sxp_link_if.tile                         link,
  input  wire logic                        wr_valid,
  input  wire logic [sxp_pkg::W-1:0]       wr_data,
  output logic                             wr_ready,
  input  wire logic                        rd_valid,
  input  wire logic                        rd_sel,
  output logic                             rd_ready,
  output logic                             rsp_valid,
  output logic [sxp_pkg::W-1:0]            rsp_data,
  input  wire logic                        load_valid,
  input  wire logic [sxp_pkg::PC_W-1:0]    load_addr,
  input  wire logic [sxp_pkg::INST_W-1:0]  load_data
);
  logic [sxp_pkg::W-1:0] hold_data;
  logic                  hold_valid;
  logic [1:0]            pop;
  logic                  imem_we;
  logic [sxp_pkg::PC_W-1:0]   imem_addr;
  logic [sxp_pkg::INST_W-1:0] imem_wdata;

  // write blocks while the hold register still holds a word, the cycle it drains included
  wire drain       = hold_valid & link.to_sw_ready;
  wire take_wr     = wr_valid & wr_ready;
  wire next_hold   = take_wr | (hold_valid & ~drain);
  wire q_has       = rd_sel ? link.from_sw_valid[1] : link.from_sw_valid[0];
  // read blocks on an empty queue; one read per two cycles since the
  // pop travels a cycle behind the capture
  wire take_rd     = rd_valid & rd_ready & q_has;
  wire [sxp_pkg::W-1:0] q_word =
    rd_sel ? link.from_sw_data_b : link.from_sw_data_a;

  assign link.to_sw_valid = hold_valid;
  assign link.to_sw_data  = hold_data;
  assign link.from_sw_rd  = pop;
  assign link.imem_we     = imem_we;
  assign link.imem_addr   = imem_addr;
  assign link.imem_wdata  = imem_wdata;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_valid <= 1'b0;
      hold_data  <= '0;
      wr_ready   <= 1'b1;
      rd_ready   <= 1'b1;
      pop        <= 2'h0;
      rsp_valid  <= 1'b0;
      rsp_data   <= '0;
      imem_we    <= 1'b0;
      imem_addr  <= '0;
      imem_wdata <= '0;
    end else if (ce) begin
      hold_valid <= next_hold;
      wr_ready   <= ~next_hold;
      if (take_wr)
        hold_data <= wr_data;
      pop       <= take_rd ? (rd_sel ? 2'h2 : 2'h1) : 2'h0;
      rd_ready  <= ~take_rd;
      rsp_valid <= take_rd;
      if (take_rd)
        rsp_data <= q_word;
      // swapping store contents is this end's job
      imem_we    <= load_valid;
      imem_addr  <= load_addr;
      imem_wdata <= load_data;
    end
  end
endmodule

/* bench/sxp_link_monitor.sv */
// assertions on the link between the tile end and the switch end
// assumes one clock; sys_rst is the tile end reset
`timescale 1ns/10ps
module sxp_link_monitor (
  input wire logic                         clock,
  input wire logic                         sys_rst,
  input wire logic                         to_sw_valid,
  input wire logic [sxp_pkg::W-1:0]        to_sw_data,
  input wire logic                         to_sw_ready,
  input wire logic [1:0]                   from_sw_valid,
  input wire logic [sxp_pkg::W-1:0]        from_sw_data_a,
  input wire logic [sxp_pkg::W-1:0]        from_sw_data_b,
  input wire logic [1:0]                   from_sw_rd,
  input wire logic                         imem_we,
  input wire logic [sxp_pkg::PC_W-1:0]     imem_addr,
  input wire logic [sxp_pkg::INST_W-1:0]   imem_wdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_pop_a_nonempty: assert property (from_sw_rd[0] |-> from_sw_valid[0])
    else $error("queue a popped while empty");
  a_pop_b_nonempty: assert property (from_sw_rd[1] |-> from_sw_valid[1])
    else $error("queue b popped while empty");
  a_pop_a_single: assert property (from_sw_rd[0] |=> !from_sw_rd[0])
    else $error("queue a popped twice in a row");
  a_pop_b_single: assert property (from_sw_rd[1] |=> !from_sw_rd[1])
    else $error("queue b popped twice in a row");
  a_write_blocks_held: assert property (to_sw_valid && !to_sw_ready |=>
    to_sw_valid && $stable(to_sw_data))
    else $error("blocked write word dropped or changed");
  a_write_taken_once: assert property (to_sw_valid && to_sw_ready |=>
    !to_sw_valid)
    else $error("accepted write word offered again");
  a_head_a_stable: assert property (from_sw_valid[0] && !from_sw_rd[0] |=>
    from_sw_valid[0] && $stable(from_sw_data_a))
    else $error("queue a head changed without a pop");
  a_head_b_stable: assert property (from_sw_valid[1] && !from_sw_rd[1] |=>
    from_sw_valid[1] && $stable(from_sw_data_b))
    else $error("queue b head changed without a pop");
  a_store_addr_range: assert property (imem_we |->
    imem_addr <= sxp_pkg::PC_LAST)
    else $error("store write beyond last entry");
  a_reset_link_idle: assert property (disable iff (1'b0)
    sys_rst |=> !to_sw_valid && from_sw_rd == 2'h0 && !imem_we)
    else $error("link not idle after reset");

  c_write_taken: cover property (to_sw_valid && to_sw_ready);
  c_pop_a: cover property (from_sw_rd[0]);
  c_pop_b: cover property (from_sw_rd[1]);
endmodule

/* bench/sxp_tb_top.sv */
// bench joining the tile end and the switch end over one link
// assumes switch program is loaded while the switch is held in reset
`timescale 1ns/10ps
module sxp_tb_top;
  logic                                      clock = 1'b0;
  logic                                      sys_rst = 1'b1;
  logic                                      sw_rst = 1'b1;
  logic                                      ce = 1'b1;
  logic [sxp_pkg::N_NB-1:0]                  nb_in_valid = '0;
  logic [sxp_pkg::N_NB-1:0][sxp_pkg::W-1:0]  nb_in_data = '0;
  logic [sxp_pkg::N_NB-1:0]                  nb_in_ready;
  logic [sxp_pkg::N_NB-1:0]                  nb_out_valid;
  logic [sxp_pkg::N_NB-1:0][sxp_pkg::W-1:0]  nb_out_data;
  logic [sxp_pkg::N_NB-1:0]                  nb_out_ready = 8'hff;
  logic                                      stalled;
  logic                                      wr_valid = 1'b0;
  logic [sxp_pkg::W-1:0]                     wr_data = '0;
  logic                                      wr_ready;
  logic                                      rd_valid = 1'b0;
  logic                                      rd_sel = 1'b0;
  logic                                      rd_ready;
  logic                                      rsp_valid;
  logic [sxp_pkg::W-1:0]                     rsp_data;
  logic                                      load_valid = 1'b0;
  logic [sxp_pkg::PC_W-1:0]                  load_addr = '0;
  logic [sxp_pkg::INST_W-1:0]                load_data = '0;
  int                                        num_errors = 0;
  int                                        checks_done = 0;
  int                                        cycles = 0;

  sxp_link_if sxp_link_if_i ();
  sxp_switch sxp_switch_i (.clock(clock), .sys_rst(sw_rst), .ce(ce),
    .link(sxp_link_if_i), .nb_in_valid(nb_in_valid),
    .nb_in_data(nb_in_data), .nb_in_ready(nb_in_ready),
    .nb_out_valid(nb_out_valid), .nb_out_data(nb_out_data),
    .nb_out_ready(nb_out_ready), .stalled(stalled));
  sxp_tile sxp_tile_i (.clock(clock), .sys_rst(sys_rst), .ce(ce),
    .link(sxp_link_if_i), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_sel(rd_sel),
    .rd_ready(rd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .load_valid(load_valid), .load_addr(load_addr),
    .load_data(load_data));
  sxp_link_monitor sxp_link_monitor_i (.clock(clock), .sys_rst(sys_rst),
    .to_sw_valid(sxp_link_if_i.to_sw_valid),
    .to_sw_data(sxp_link_if_i.to_sw_data),
    .to_sw_ready(sxp_link_if_i.to_sw_ready),
    .from_sw_valid(sxp_link_if_i.from_sw_valid),
    .from_sw_data_a(sxp_link_if_i.from_sw_data_a),
    .from_sw_data_b(sxp_link_if_i.from_sw_data_b),
    .from_sw_rd(sxp_link_if_i.from_sw_rd),
    .imem_we(sxp_link_if_i.imem_we), .imem_addr(sxp_link_if_i.imem_addr),
    .imem_wdata(sxp_link_if_i.imem_wdata));

  initial begin
    forever #20 clock = ~clock;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // whole run needs well under a hundred cycles; a stuck branch lands here
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [63:0] ins(logic [1:0] op, logic [1:0] dst,
      logic [3:0] src, logic [12:0] tgt, logic [39:0] rt);
    ins = {op, dst, src, 3'h0, tgt, rt};
  endfunction

  task automatic load(logic [12:0] a, logic [63:0] d);
    load_valid = 1'b1;
    load_addr = a;
    load_data = d;
    @(negedge clock);
  endtask

  task automatic tile_write(logic [31:0] d);
    wr_valid = 1'b1;
    wr_data = d;
    while (wr_ready !== 1'b1) @(negedge clock);
    @(negedge clock);
    wr_valid = 1'b0;
  endtask

  task automatic tile_read(logic s, logic [31:0] exp);
    rd_valid = 1'b1;
    rd_sel = s;
    while (!(rd_ready === 1'b1 && sxp_link_if_i.from_sw_valid[s] === 1'b1))
      @(negedge clock);
    @(negedge clock);
    rd_valid = 1'b0;
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("rsp_data", exp, rsp_data);
  endtask

  task automatic nb_send(int i, logic [31:0] d);
    nb_in_valid[i] = 1'b1;
    nb_in_data[i] = d;
    while (nb_in_ready[i] !== 1'b1) @(negedge clock);
    @(negedge clock);
    nb_in_valid[i] = 1'b0;
    nb_in_data[i] = ~d;
  endtask

  task automatic nb_expect(int i, logic [31:0] exp);
    while (nb_out_valid[i] !== 1'b1) @(negedge clock);
    chk("nb_out_data", exp, nb_out_data[i]);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    // load_valid stays up across the batch and is lowered once after it
    load(13'h0, ins(sxp_pkg::SXP_OP_NOP, 2'h0, 4'h0, 13'h0, 40'h101));
    load(13'h1, ins(sxp_pkg::SXP_OP_MOVE, 2'h1, 4'h2, 13'h0, 40'h30));
    load(13'h2, ins(sxp_pkg::SXP_OP_BEQZ, 2'h0, 4'hd, 13'h7, 40'h0));
    load(13'h3, ins(sxp_pkg::SXP_OP_BEQZ, 2'h0, 4'h1, 13'h5, 40'h0));
    load(13'h4, ins(sxp_pkg::SXP_OP_JUMP, 2'h0, 4'h0, 13'h4, 40'h0));
    load(13'h5, ins(sxp_pkg::SXP_OP_JUMP, 2'h0, 4'h5, 13'h0, 40'h5000));
    load(13'h7, ins(sxp_pkg::SXP_OP_JUMP, 2'h0, 4'h0, 13'h7, 40'h0));
    load(13'h8, ins(sxp_pkg::SXP_OP_NOP, 2'h0, 4'h0, 13'h0, 40'h1));
    load(13'h9, ins(sxp_pkg::SXP_OP_JUMP, 2'h0, 4'h0, 13'h9, 40'h0));
    load_valid = 1'b0;
    repeat (2) @(negedge clock);
    sw_rst = 1'b0;
    @(negedge clock);
    chk("nb_in_ready", 32'hff, {24'h0, nb_in_ready});
    chk("nb_out_valid", 32'h0, {24'h0, nb_out_valid});
    // pc 0 names the empty processor queue, so it stalls at once
    chk("stalled", 32'h1, {31'h0, stalled});
    // one processor word fans out to north and to queue a
    tile_write(32'h1234abcd);
    nb_expect(0, 32'h1234abcd);
    tile_read(1'b0, 32'h1234abcd);
    // move waits for its east route source; nothing may leak meanwhile
    nb_send(0, 32'h55aa0011);
    repeat (3) @(negedge clock);
    chk("stalled", 32'h1, {31'h0, stalled});
    chk("queue b valid", 32'h0, {31'h0, sxp_link_if_i.from_sw_valid[1]});
    nb_send(1, 32'h0f0f0f0f);
    tile_read(1'b1, 32'h0f0f0f0f);
    // r1 nonzero falls through; zero from processor branches to 5
    nb_out_ready[1] = 1'b0;
    tile_write(32'h0);
    nb_send(3, 32'h8);
    nb_expect(1, 32'h8);
    repeat (3) @(negedge clock);
    chk("east out held", 32'h1, {31'h0, nb_out_valid[1]});
    chk("east out data", 32'h8, nb_out_data[1]);
    nb_out_ready[1] = 1'b1;
    // jump target came from the west word: pc 8 routes to queue a, as pc 0 also does
    tile_write(32'hc0ffee01);
    tile_read(1'b0, 32'hc0ffee01);
    repeat (4) @(negedge clock);
    print_verdict();
  end
endmodule
